// *** src/gipm_pkg.sv ***
package gipm_pkg;

    // Pad and catalogue geometry
    localparam int NPAD = 44;
    localparam int NCODE = 128;
    localparam int NGRP = 4;
    localparam logic [5:0] PADS_SMALL = 6'h0c;
    localparam logic [5:0] PADS_MEDIUM = 6'h1c;
    localparam logic [5:0] PADS_LARGE = 6'h2c;

    // Package variants
    localparam logic [1:0] PKG_SMALL = 2'h0;
    localparam logic [1:0] PKG_MEDIUM = 2'h1;
    localparam logic [1:0] PKG_LARGE = 2'h2;

    // Pad modes
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] MODE_OUT = 2'h1;
    localparam logic [1:0] MODE_BIDIR = 2'h2;

    // Signal codes: the two low bits of a code are its routing group
    localparam logic [6:0] C_NONE = 7'h00;
    localparam logic [6:0] C_DEBUG = 7'h04;
    localparam logic [6:0] C_UART = 7'h08;
    localparam logic [6:0] C_SPI_S0 = 7'h14;
    localparam logic [6:0] C_SPI_S1 = 7'h18;
    localparam logic [6:0] C_SPI_M = 7'h1c;
    localparam logic [6:0] C_FCTL = 7'h24;
    localparam logic [6:0] C_FDATA = 7'h2c;
    localparam logic [6:0] C_PWM = 7'h34;
    localparam logic [6:0] C_GPIO = 7'h3c;
    localparam logic [6:0] C_END = 7'h64;

    // Field offsets inside peripherals
    localparam logic [6:0] UART_TX_ACTIVE = 7'h08;
    localparam logic [6:0] SPI_SS = 7'h03;
    localparam logic [6:0] SPIM_SS1 = 7'h04;
    localparam logic [6:0] FCTL_OE = 7'h04;
    localparam logic [6:0] FCTL_CLKOUT = 7'h05;

    typedef logic [1:0] gipm_dir_type; // {can drive pad, can be read from pad}

    // Which way each catalogue signal flows
    function automatic gipm_dir_type gipm_dir(input logic [6:0] c);
        gipm_dir_type d;
        d = 2'h0;
        if (c == C_DEBUG) d = 2'h3;
        else if (c >= C_UART && c < C_UART + 7'h09)
            d = (c == C_UART || c == C_UART + 7'h02 || c == C_UART + 7'h04
                 || c == C_UART + UART_TX_ACTIVE) ? 2'h2 : 2'h1;
        else if (c >= C_SPI_S0 && c < C_SPI_M)
            d = (c[1:0] == 2'h1) ? 2'h3 : ((c[1:0] == 2'h2) ? 2'h2 : 2'h1);
        else if (c >= C_SPI_M && c <= C_SPI_M + SPIM_SS1)
            d = (c == C_SPI_M + 7'h01) ? 2'h3 : ((c == C_SPI_M + 7'h02) ? 2'h1 : 2'h2);
        else if (c >= C_FCTL && c <= C_FCTL + FCTL_CLKOUT)
            d = (c < C_FCTL + 7'h02) ? 2'h2 : 2'h1;
        else if (c >= C_FDATA && c < C_PWM) d = 2'h3;
        else if (c >= C_PWM && c < C_GPIO) d = 2'h2;
        else if (c >= C_GPIO && c < C_END) d = 2'h3;
        return d;
    endfunction

    // Signals that are asserted low at the pad
    function automatic logic gipm_actlow(input logic [6:0] c);
        return (c >= C_UART + 7'h02 && c < C_UART + UART_TX_ACTIVE)
            || c == C_SPI_S0 + SPI_SS || c == C_SPI_S1 + SPI_SS
            || c == C_SPI_M + SPI_SS || c == C_SPI_M + SPIM_SS1
            || (c >= C_FCTL && c <= C_FCTL + FCTL_OE);
    endfunction

    function automatic logic gipm_sync_only(input logic [6:0] c);
        return c == C_FCTL + FCTL_OE || c == C_FCTL + FCTL_CLKOUT;
    endfunction

    function automatic logic [5:0] gipm_pad_count(input logic [1:0] pkg);
        return (pkg == PKG_SMALL) ? PADS_SMALL : ((pkg == PKG_MEDIUM) ? PADS_MEDIUM : PADS_LARGE);
    endfunction

    // Default signal per pad and package; pads left at C_NONE stay inputs
    function automatic logic [6:0] gipm_default(input logic [1:0] pkg, input logic [5:0] p);
        logic [6:0] q;
        logic [6:0] c;
        q = {1'b0, p};
        c = C_NONE;
        if (p == 6'h00) c = C_DEBUG;
        else if (pkg == PKG_SMALL) begin
            if (p < 6'h04) c = C_GPIO + q;
            else if (p < 6'h08) c = C_UART + q - 7'h04;
            else if (p < 6'h0c) c = C_SPI_S0 + q - 7'h08;
        end
        else if (pkg == PKG_MEDIUM) begin
            if (p < 6'h04) c = C_PWM + q;
            else if (p < 6'h08) c = C_SPI_S0 + q - 7'h04;
            else if (p < 6'h0c) c = C_SPI_M + q - 7'h08;
            else if (p < 6'h15) c = C_UART + q - 7'h0c;
            else if (p < 6'h18) c = C_GPIO + q - 7'h10;
            else if (p < 6'h1c) c = C_GPIO + q - 7'h18;
        end
        else begin
            if (p >= 6'h04 && p < 6'h0c) c = C_FDATA + q - 7'h04;
            else if (p >= 6'h0c && p < 6'h11) c = C_FCTL + q - 7'h0c;
            else if (p >= 6'h14 && p < 6'h1d) c = C_UART + q - 7'h14;
            else if (p >= 6'h20 && p < 6'h24) c = C_SPI_S0 + q - 7'h20;
            else if (p >= 6'h24 && p < 6'h28) c = C_SPI_S1 + q - 7'h24;
            else if (p >= 6'h28 && p < 6'h2c) c = C_SPI_M + q - 7'h28;
        end
        return c;
    endfunction

    // Default pad mode follows the signal's direction
    function automatic logic [1:0] gipm_def_mode(input logic [6:0] c);
        gipm_dir_type d;
        d = gipm_dir(c);
        return (d == 2'h3) ? MODE_BIDIR : ((d == 2'h2) ? MODE_OUT : MODE_IN);
    endfunction

endpackage

// *** src/gipm_pad_cell.sv ***
`timescale 1ns/1ps
module gipm_pad_cell
    import gipm_pkg::*;
#(
    parameter logic [1:0] PAD_GRP = 2'h0
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Control from the top
    input wire logic i_live,
    input wire logic i_active,
    input wire logic i_load_default,
    input wire logic [4:0] i_def_slot,
    input wire logic [1:0] i_def_mode,
    input wire logic i_wr,
    input wire logic [4:0] i_wr_slot,
    input wire logic [1:0] i_wr_mode,
    // Catalogue of peripheral drive values
    input wire logic [NCODE-1:0] i_sig_out,
    input wire logic [NCODE-1:0] i_sig_oe,
    // Pad side and configuration readback
    output logic o_pad_out,
    output logic o_pad_oe_n,
    output logic [4:0] o_slot,
    output logic [1:0] o_mode
);

    typedef struct packed {
        logic [4:0] slot;
        logic [1:0] mode;
        logic custom;
        logic pad_out;
        logic pad_oe_n;
    } gipm_cell_type;

    gipm_cell_type st;
    gipm_cell_type next_st;
    logic [6:0] code;
    logic drive;

    // The group bits are fixed per pad, so a signal can never reach a foreign group
    assign code = {st.slot, PAD_GRP};

    always_comb
    begin
        next_st = st;
        if (!i_live)
        begin
            next_st.slot = C_NONE[6:2];
            next_st.mode = MODE_IN;
            next_st.custom = 1'b0;
        end
        else if (i_wr)
        begin
            next_st.slot = i_wr_slot;
            next_st.mode = i_wr_mode;
            next_st.custom = 1'b1;
        end
        else if (i_load_default && !st.custom)
        begin
            next_st.slot = i_def_slot;
            next_st.mode = i_def_mode;
        end
        // Only one source per pad exists by construction
        drive = i_active && i_live && (st.slot != C_NONE[6:2])
            && (st.mode == MODE_OUT || (st.mode == MODE_BIDIR && i_sig_oe[code]));
        next_st.pad_oe_n = !drive;
        next_st.pad_out = drive && (i_sig_out[code] ^ gipm_actlow(code));
    end

    // All pads come out of reset as undriven inputs
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            st <= '0;
            st.mode <= MODE_IN;
            st.pad_oe_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign o_pad_out = st.pad_out;
    assign o_pad_oe_n = st.pad_oe_n;
    assign o_slot = st.slot;
    assign o_mode = st.mode;

endmodule

// *** src/gipm_mux.sv ***
// Notes on behaviour
// - Configuration picks which peripheral function serves each pad.
// - Each signal sits in one of four groups, one pad per four.
// - A group g signal reaches only pads whose index mod four is g.
// - Each pad is input, output, or bidirectional switched by its peripheral.
// - After power-on reset every pad is an undriven input.
// - Enabling the mux loads package defaults where nothing else was chosen.
// - Synchronous FIFO signals cannot be selected in the small package.
// - Pad counts are 12, 28 and 44 for small, medium and large.
// - Peripheral widths: UART 9, SPI slaves 4, master 5, FIFO 14, GPIO 40.
// - Peripherals may be mapped partly, leaving other signals unconnected.
// - Each GPIO bit has a fixed group and stays unplaced without a pad.
// - Defaults follow a fixed table per package variant.
// - Hash-marked signals are inverted at the pad.
`timescale 1ns/1ps
module gipm_mux
    import gipm_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Static package selection and enable
    input wire logic [1:0] i_package,
    input wire logic i_mux_enable,
    // Configuration write port
    input wire logic i_cfg_wr,
    input wire logic [5:0] i_cfg_pad,
    input wire logic [4:0] i_cfg_slot,
    input wire logic [1:0] i_cfg_mode,
    output logic o_cfg_reject,
    output logic o_mux_active,
    // Debug wire
    input wire logic i_debug_out,
    input wire logic i_debug_oe,
    output logic o_debug_in,
    // UART: txd rxd rts cts dtr dsr dcd ri tx_active
    input wire logic [8:0] i_uart_out,
    output logic [8:0] o_uart_in,
    // SPI slaves: clk mosi miso ss
    input wire logic [3:0] i_spi_s0_out,
    input wire logic [3:0] i_spi_s0_oe,
    output logic [3:0] o_spi_s0_in,
    input wire logic [3:0] i_spi_s1_out,
    input wire logic [3:0] i_spi_s1_oe,
    output logic [3:0] o_spi_s1_in,
    // SPI master: clk mosi miso ss0 ss1
    input wire logic [4:0] i_spi_m_out,
    input wire logic [4:0] i_spi_m_oe,
    output logic [4:0] o_spi_m_in,
    // FIFO control: rxf txe rd wr oe clkout, and data
    input wire logic [5:0] i_fifo_ctl_out,
    output logic [5:0] o_fifo_ctl_in,
    input wire logic [7:0] i_fifo_data_out,
    input wire logic [7:0] i_fifo_data_oe,
    output logic [7:0] o_fifo_data_in,
    // PWM and GPIO
    input wire logic [7:0] i_pwm_out,
    input wire logic [39:0] i_gpio_out,
    input wire logic [39:0] i_gpio_oe,
    output logic [39:0] o_gpio_in,
    // Pads
    input wire logic [NPAD-1:0] i_pad_in,
    output logic [NPAD-1:0] o_pad_out,
    output logic [NPAD-1:0] o_pad_oe_n
);

    typedef struct packed {
        logic enable_seen;
        logic active;
        logic cfg_reject;
        logic [NCODE-1:0] sig_in;
    } gipm_state_type;

    gipm_state_type st;
    gipm_state_type next_st;
    logic [NCODE-1:0] sig_out;
    logic [NCODE-1:0] sig_oe;
    logic [5:0] pad_count;
    logic load_default;
    logic cfg_ok;
    logic [6:0] cfg_code;
    logic [4:0] pad_slot [NPAD];
    logic [1:0] pad_mode [NPAD];

    assign pad_count = gipm_pad_count(i_package);
    assign load_default = i_mux_enable && !st.enable_seen;
    assign cfg_code = {i_cfg_slot, i_cfg_pad[1:0]};

    // Writes outside the package, with mode 3, to codes at or past C_END or to sync FIFO on small parts are refused
    assign cfg_ok = (i_cfg_pad < pad_count) && (i_cfg_mode != 2'h3)
        && (cfg_code < C_END)
        && !(gipm_sync_only(cfg_code) && i_package == PKG_SMALL);

    // Flatten peripheral drive into the catalogue; UART, FIFO control and PWM outputs drive always
    always_comb
    begin
        gipm_dir_type dir_c;
        dir_c = '0;
        sig_out = '0;
        sig_oe = '0;
        sig_out[C_DEBUG] = i_debug_out;
        sig_oe[C_DEBUG] = i_debug_oe;
        sig_out[C_UART +: 9] = i_uart_out;
        sig_oe[C_UART +: 9] = '1;
        sig_out[C_SPI_S0 +: 4] = i_spi_s0_out;
        sig_oe[C_SPI_S0 +: 4] = i_spi_s0_oe;
        sig_out[C_SPI_S1 +: 4] = i_spi_s1_out;
        sig_oe[C_SPI_S1 +: 4] = i_spi_s1_oe;
        sig_out[C_SPI_M +: 5] = i_spi_m_out;
        sig_oe[C_SPI_M +: 5] = i_spi_m_oe;
        sig_out[C_FCTL +: 6] = i_fifo_ctl_out;
        sig_oe[C_FCTL +: 6] = '1;
        sig_out[C_FDATA +: 8] = i_fifo_data_out;
        sig_oe[C_FDATA +: 8] = i_fifo_data_oe;
        sig_out[C_PWM +: 8] = i_pwm_out;
        sig_oe[C_PWM +: 8] = '1;
        sig_out[C_GPIO +: 40] = i_gpio_out;
        sig_oe[C_GPIO +: 40] = i_gpio_oe;
        // Input-only signals lose their output enable, so only a pad set to MODE_OUT can drive them
        for (int c = 0; c < NCODE; c++)
        begin
            // A function result cannot be bit-selected directly, so it lands in a local first
            dir_c = gipm_dir(7'(c));
            if (!dir_c[1])
                sig_oe[c] = 1'b0;
        end
    end

    // One cell per pad; a pad's group is its index modulo four
    for (genvar p = 0; p < NPAD; p++)
    begin : g_pad
        logic [6:0] def_code;
        assign def_code = gipm_default(i_package, 6'(p));

        gipm_pad_cell #(
            .PAD_GRP(2'(p % NGRP))
        ) u_cell (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_live(6'(p) < pad_count),
            .i_active(st.active),
            .i_load_default(load_default),
            .i_def_slot(def_code[6:2]),
            .i_def_mode(gipm_def_mode(def_code)),
            .i_wr(i_cfg_wr && cfg_ok && i_cfg_pad == 6'(p)),
            .i_wr_slot(i_cfg_slot),
            .i_wr_mode(i_cfg_mode),
            .i_sig_out(sig_out),
            .i_sig_oe(sig_oe),
            .o_pad_out(o_pad_out[p]),
            .o_pad_oe_n(o_pad_oe_n[p]),
            .o_slot(pad_slot[p]),
            .o_mode(pad_mode[p])
        );
    end

    // Route pads back to peripheral inputs
    always_comb
    begin
        logic [6:0] code;
        gipm_dir_type dir_p;
        code = '0;
        dir_p = '0;
        next_st = st;
        next_st.enable_seen = i_mux_enable;
        next_st.active = i_mux_enable;
        next_st.cfg_reject = i_cfg_wr && !cfg_ok;
        next_st.sig_in = '0;
        // Walk downward so the lowest pad claiming a signal is the one heard
        for (int p = NPAD - 1; p >= 0; p--)
        begin
            code = {pad_slot[p], 2'(p % NGRP)};
            dir_p = gipm_dir(code);
            if (st.active && 6'(p) < pad_count && pad_slot[p] != C_NONE[6:2]
                && pad_mode[p] != MODE_OUT && dir_p[0])
                next_st.sig_in[code] = i_pad_in[p] ^ gipm_actlow(code);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    // Unpack catalogue inputs; unused codes stay at zero, the inactive level
    assign o_cfg_reject = st.cfg_reject;
    assign o_mux_active = st.active;
    assign o_debug_in = st.sig_in[C_DEBUG];
    assign o_uart_in = st.sig_in[C_UART +: 9];
    assign o_spi_s0_in = st.sig_in[C_SPI_S0 +: 4];
    assign o_spi_s1_in = st.sig_in[C_SPI_S1 +: 4];
    assign o_spi_m_in = st.sig_in[C_SPI_M +: 5];
    assign o_fifo_ctl_in = st.sig_in[C_FCTL +: 6];
    assign o_fifo_data_in = st.sig_in[C_FDATA +: 8];
    assign o_gpio_in = st.sig_in[C_GPIO +: 40];

endmodule

// *** dv/gipm_mux_asserts.sv ***
`timescale 1ns/1ps
module gipm_mux_asserts
    import gipm_pkg::*;
(
    // Clock, reset and controls
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [1:0] i_package,
    input wire logic i_mux_enable,
    input wire logic i_cfg_wr,
    input wire logic [5:0] i_cfg_pad,
    input wire logic [4:0] i_cfg_slot,
    input wire logic [1:0] i_cfg_mode,
    // Observed outputs
    input wire logic o_cfg_reject,
    input wire logic o_mux_active,
    input wire logic [8:0] o_uart_in,
    input wire logic [39:0] o_gpio_in,
    input wire logic [NPAD-1:0] o_pad_out,
    input wire logic [NPAD-1:0] o_pad_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Pad limit and code of the write on offer
    logic [5:0] pad_limit;
    logic [6:0] wr_code;
    logic sync_bad;
    assign pad_limit = (i_package == PKG_SMALL) ? PADS_SMALL
        : ((i_package == PKG_MEDIUM) ? PADS_MEDIUM : PADS_LARGE);
    assign wr_code = {i_cfg_slot, i_cfg_pad[1:0]};
    assign sync_bad = i_package == PKG_SMALL && (wr_code == 7'h28 || wr_code == 7'h29);

    // Reset must win even while the check itself would be disabled
    a_reset_idle: assert property (disable iff (1'b0)
        !i_reset_n |=> o_pad_oe_n == '1 && o_pad_out == '0)
        else $error("pads not idle after reset");
    a_active_copy: assert property (
        $past(i_reset_n) |-> o_mux_active == $past(i_mux_enable))
        else $error("active flag does not follow enable");
    a_disable_idle: assert property (
        !i_mux_enable [*2] |-> ##1 o_pad_oe_n == '1)
        else $error("pad driven while mux disabled");
    a_range_reject: assert property (
        i_cfg_wr && i_cfg_pad >= pad_limit |=> o_cfg_reject)
        else $error("write past pad count accepted");
    a_mode_reject: assert property (
        i_cfg_wr && i_cfg_mode == 2'h3 |=> o_cfg_reject)
        else $error("illegal mode accepted");
    a_sync_reject: assert property (
        i_cfg_wr && sync_bad |=> o_cfg_reject)
        else $error("sync fifo signal accepted on small package");
    a_good_accept: assert property (
        i_cfg_wr && i_cfg_pad < pad_limit && i_cfg_mode != 2'h3 && wr_code < C_END
        && !sync_bad |=> !o_cfg_reject)
        else $error("legal write refused");
    a_reject_cause: assert property (
        o_cfg_reject |-> $past(i_cfg_wr))
        else $error("refusal without a write");
    a_inputs_idle: assert property (
        !o_mux_active && !i_mux_enable |=> o_uart_in == '0 && o_gpio_in == '0)
        else $error("peripheral input moved while mux inactive");
endmodule

bind gipm_mux gipm_mux_asserts i_chk (
    .i_clk, .i_reset_n, .i_package, .i_mux_enable, .i_cfg_wr, .i_cfg_pad,
    .i_cfg_slot, .i_cfg_mode, .o_cfg_reject, .o_mux_active, .o_uart_in,
    .o_gpio_in, .o_pad_out, .o_pad_oe_n
);

// *** dv/gipm_pad_model.sv ***
`timescale 1ns/1ps
module gipm_pad_model
    import gipm_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Device pad drivers, low enable means driving
    input wire logic [NPAD-1:0] i_pad_out,
    input wire logic [NPAD-1:0] i_pad_oe_n,
    // Board drivers set by the bench
    input wire logic [NPAD-1:0] i_ext_en,
    input wire logic [NPAD-1:0] i_ext_val,
    // Resolved pad level
    output logic [NPAD-1:0] o_level
);
    // No pulls on the pads, so a floating pad wanders instead of holding
    logic [NPAD-1:0] float_val = '0;
    always @(posedge i_clk)
    begin
        float_val <= ~float_val;
    end
    // Device driver first, then board, then the floating pattern
    assign o_level = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & i_ext_en & i_ext_val)
        | (i_pad_oe_n & ~i_ext_en & float_val);
endmodule

// *** dv/gipm_mux_tb.sv ***
`timescale 1ns/1ps
module gipm_mux_tb;
    import gipm_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_mux_enable = 1'b0, i_cfg_wr = 1'b0;
    logic [1:0] i_package = PKG_LARGE, i_cfg_mode = 2'h0;
    logic [5:0] i_cfg_pad = 6'h00;
    logic [4:0] i_cfg_slot = 5'h00;
    logic i_debug_out = 1'b0, i_debug_oe = 1'b0;
    logic o_cfg_reject, o_mux_active, o_debug_in;
    logic [8:0] i_uart_out = 9'h000, o_uart_in;
    logic [3:0] i_spi_s0_out = 4'h0, i_spi_s0_oe = 4'hf, o_spi_s0_in;
    logic [3:0] i_spi_s1_out = 4'h0, i_spi_s1_oe = 4'h0, o_spi_s1_in;
    logic [4:0] i_spi_m_out = 5'h00, i_spi_m_oe = 5'h00, o_spi_m_in;
    logic [5:0] i_fifo_ctl_out = 6'h00, o_fifo_ctl_in;
    logic [7:0] i_fifo_data_out = 8'h00, i_fifo_data_oe = 8'h00, o_fifo_data_in;
    logic [7:0] i_pwm_out = 8'h00;
    logic [39:0] i_gpio_out = '1, i_gpio_oe = '0, o_gpio_in;
    logic [NPAD-1:0] pad_level, o_pad_out, o_pad_oe_n, ext_en = '0, ext_val = '0;
    int bad_count = 0, num_checks = 0, cycles = 0;

    gipm_mux i_dut (
        .i_clk, .i_reset_n, .i_package, .i_mux_enable, .i_cfg_wr, .i_cfg_pad, .i_cfg_slot,
        .i_cfg_mode, .o_cfg_reject, .o_mux_active, .i_debug_out, .i_debug_oe, .o_debug_in,
        .i_uart_out, .o_uart_in, .i_spi_s0_out, .i_spi_s0_oe, .o_spi_s0_in, .i_spi_s1_out,
        .i_spi_s1_oe, .o_spi_s1_in, .i_spi_m_out, .i_spi_m_oe, .o_spi_m_in, .i_fifo_ctl_out,
        .o_fifo_ctl_in, .i_fifo_data_out, .i_fifo_data_oe, .o_fifo_data_in, .i_pwm_out,
        .i_gpio_out, .i_gpio_oe, .o_gpio_in, .i_pad_in(pad_level), .o_pad_out, .o_pad_oe_n
    );
    gipm_pad_model i_pads (
        .i_clk, .i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_level(pad_level)
    );

    // Clock and a hang guard sized well above the whole sequence
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Leaves the strobe high so writes can run back to back
    task automatic wr(input logic [5:0] pad, input logic [4:0] slot, input logic [1:0] mode);
        i_cfg_wr = 1'b1;
        i_cfg_pad = pad;
        i_cfg_slot = slot;
        i_cfg_mode = mode;
        @(negedge i_clk);
    endtask

    task automatic test_reset();
        cyc(12);
        check({o_pad_oe_n, o_pad_out}, {{NPAD{1'b1}}, {NPAD{1'b0}}});
        check({o_mux_active, o_uart_in, o_gpio_in}, 50'h0);
        i_reset_n = 1'b1;
        cyc(1);
    endtask
    // Large package map after enable, pads 14, 21, 23, 35, 39 and 42 driven by the board
    task automatic test_defaults();
        i_uart_out = 9'h005;
        i_fifo_data_out = 8'h01;
        i_fifo_data_oe = 8'h01;
        i_fifo_ctl_out = 6'h01;
        i_spi_s0_out = 4'hf;
        i_spi_s0_oe = 4'h0;
        i_pwm_out = 8'hff;
        i_debug_out = 1'b1;
        i_debug_oe = 1'b1;
        ext_en = 44'h488_00a0_4000;
        ext_val = 44'h400_0020_0000;
        i_mux_enable = 1'b1;
        cyc(3);
        check(o_mux_active, 1'b1);
        check({o_pad_oe_n[0], o_pad_out[0]}, 2'b01);
        check({o_pad_oe_n[20], o_pad_out[20]}, 2'b01);
        check({o_pad_oe_n[22], o_pad_out[22]}, 2'b00);
        check({o_pad_oe_n[4], o_pad_out[4]}, 2'b01);
        check({o_pad_oe_n[12], o_pad_out[12]}, 2'b00);
        check({o_pad_oe_n[33], o_pad_oe_n[29]}, 2'b11);
        check(o_uart_in[3:1], 3'b101);
        check({o_debug_in, o_fifo_data_in[0], o_fifo_ctl_in[2], o_spi_s0_in[3], o_spi_s1_in[3], o_spi_m_in[2]}, 6'h3f);
    endtask
    // Pad 0 stays on the debug wire throughout
    task automatic test_config();
        wr(6'h08, 5'h02, MODE_OUT);
        wr(6'h09, 5'h02, MODE_IN);
        i_cfg_wr = 1'b0;
        i_uart_out[0] = 1'b0;
        ext_en[9] = 1'b1;
        ext_val[9] = 1'b0;
        cyc(2);
        check({o_pad_oe_n[8], o_pad_out[8], o_pad_out[20]}, 3'b000);
        check(o_uart_in[1], 1'b0);
        wr(6'h09, 5'h00, MODE_IN);
        i_cfg_wr = 1'b0;
        cyc(2);
        check(o_uart_in[1], 1'b1);
    endtask
    task automatic test_gpio();
        wr(6'h0d, 5'h0f, MODE_BIDIR);
        i_cfg_wr = 1'b0;
        ext_en[13] = 1'b1;
        ext_val[13] = 1'b1;
        cyc(2);
        check({o_pad_oe_n[13], o_gpio_in[1]}, 2'b11);
        ext_en[13] = 1'b0;
        i_gpio_oe[1] = 1'b1;
        i_gpio_out[1] = 1'b0;
        cyc(2);
        check({o_pad_oe_n[13], o_pad_out[13]}, 2'b00);
    endtask
    // Small package: {pad, slot, mode, refused}
    task automatic test_small();
        logic [13:0] t [7];
        t = '{{6'h0c, 5'h01, 2'h0, 1'b1}, {6'h0b, 5'h01, 2'h3, 1'b1},
            {6'h04, 5'h0a, 2'h0, 1'b1}, {6'h05, 5'h0a, 2'h0, 1'b1},
            {6'h08, 5'h19, 2'h0, 1'b1}, {6'h0b, 5'h07, 2'h1, 1'b0},
            {6'h04, 5'h0b, 2'h2, 1'b0}};
        i_package = PKG_SMALL;
        cyc(2);
        check(o_pad_oe_n[43:12], 32'hffffffff);
        foreach (t[k])
        begin
            wr(t[k][13:8], t[k][7:3], t[k][2:1]);
            i_cfg_wr = 1'b0;
            check(o_cfg_reject, t[k][0]);
            cyc(1);
        end
        i_spi_m_out[3] = 1'b1;
        i_spi_m_oe = 5'h1f;
        cyc(2);
        check({o_pad_oe_n[11], o_pad_out[11]}, 2'b00);
    endtask
    task automatic test_disable();
        i_mux_enable = 1'b0;
        cyc(3);
        check(o_pad_oe_n, {NPAD{1'b1}});
        check(o_uart_in, 9'h000);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        test_reset();
        test_defaults();
        test_config();
        test_gpio();
        test_small();
        test_disable();
        end_of_test();
    end
endmodule
